// [serial_params.svh]
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH

// ********************
// Register offsets
// ********************
`define OFS_CONTROL_ONE 8'h00
`define OFS_CONTROL_TWO 8'h04
`define OFS_STATUS      8'h08
`define OFS_DATA        8'h0C

// ********************
// Control one fields
// ********************
`define BIT_TX_ENABLE   0
`define BIT_RX_ENABLE   1
`define BIT_TX_STOP_LEN 2
`define BIT_EVEN_PARITY 3
`define BIT_PARITY_EN   4
`define POS_BAUD_LO     5
`define POS_BAUD_HI     7
// Control two field
`define BIT_RX_STOP_LEN 0

// ********************
// Status fields
// ********************
`define BIT_PARITY_ERR  7
`define BIT_FRAMING_ERR 6
`define BIT_OVERRUN     5
`define BIT_RX_FULL     4
`define BIT_TX_END      3
`define BIT_TX_EMPTY    2

// ********************
// Reset values
// ********************
`define RST_CONTROL_ONE 8'h00
`define RST_CONTROL_TWO 1'h0
`define RST_TX_EMPTY    1'h1
`define RST_TX_END      1'h1
`define RST_RX_BUFFER   8'h00

// ********************
// Timing counts
// ********************
`define DIV_CODE0       9'd13
`define DIV_CODE1       9'd26
`define DIV_CODE2       9'd52
`define DIV_CODE3       9'd104
`define DIV_CODE4       9'd208
`define DIV_CODE5       9'd416
`define DIV_CODE7       9'd96
`define BAUD_TIMER_CODE 3'h6
`define RT_SAMPLE_A     4'h7
`define RT_SAMPLE_B     4'h8
`define RT_SAMPLE_C     4'h9
`define RT_LAST         4'hF
`define DATA_BITS       4'h8
`define FRAME_BASE_LEN  4'hA

`endif

// [serial_pkg.sv]
// Types and shared arithmetic of the serial port
package serial_pkg;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP1 = 3'b100,
    RX_STOP2 = 3'b101
  } rx_state_t;

  // Parity bit for a byte, even or odd
  function automatic logic parity_of(input logic [7:0] d, input logic even);
    parity_of = (^d) ^ ~even;
  endfunction : parity_of

endpackage : serial_pkg

// [serial_port.sv]
// Asynchronous serial port: APB registers, baud timing, receiver and flags
//
// Operation
// - Parity bit added only when enabled; odd or even as selected.
// - Accepted buffer write clears empty flag; character shifts out serially.
// - Frame: low start, data, optional parity, one or two stop bits.
// - On transmit start, empty flag sets and transmit interrupt pulses.
// - Line high while disabled and until first character is written.
// - Buffer write without prior status read is ignored entirely.
// - After stop bits, data goes to receive buffer, full flag, interrupt.
// - Overrun discards new character; receive buffer keeps old contents.
// - Receive disable takes effect only when current frame completes.
// - Parity error flag sets when received parity mismatches data.
// - Status read then buffer read clears error and full flags.
// - Framing error flag sets when a stop bit samples low.
// - Overrun sets when a whole frame arrives while buffer unread.
// - No reception while overrun flag stays set.
// - Overrun arising after status read survives the following buffer read.
// - Transmit end sets when sent and buffer empty; clears on start.
// - Baud for both directions comes from the selected clock source.
// - Each bit sampled at ticks 7, 8, 9; majority decides.
// - Bit rate is transfer clock over 16; code 110 uses timer.
`timescale 1ns/1ps
`include "serial_params.svh"

module serial_port
  import serial_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Baud source
  input  wire logic        TIMER_THREE_OUTPUT,
  // Serial line
  input  wire logic        RXD,
  output logic             TXD,
  // Event pulses
  output logic             TRANSMIT_INTERRUPT,
  output logic             RECEIVE_INTERRUPT
);

  // ********************
  // Registers and flags
  // ********************
  logic [7:0] serial_control_one;
  logic       receive_stop_length;
  logic [7:0] transmit_buffer;
  logic [7:0] receive_buffer;
  logic       tx_buffer_empty_flag;
  logic       transmit_end_flag;
  logic       rx_buffer_full_flag;
  logic       parity_error_flag;
  logic       framing_error_flag;
  logic       overrun_flag;
  logic       tx_armed;
  logic       rx_armed;
  logic       overrun_seen;

  logic       transmit_enable_bit;
  logic       receive_enable_bit;
  logic       transmit_stop_length;
  logic       even_parity_bit;
  logic       parity_enable_bit;
  logic [2:0] baud_select_field;
  assign transmit_enable_bit  = serial_control_one[`BIT_TX_ENABLE];
  assign receive_enable_bit   = serial_control_one[`BIT_RX_ENABLE];
  assign transmit_stop_length = serial_control_one[`BIT_TX_STOP_LEN];
  assign even_parity_bit      = serial_control_one[`BIT_EVEN_PARITY];
  assign parity_enable_bit    = serial_control_one[`BIT_PARITY_EN];
  assign baud_select_field    = serial_control_one[`POS_BAUD_HI:`POS_BAUD_LO];

  // ********************
  // APB decode
  // ********************
  logic       acc_done;
  logic       wr_done;
  logic       rd_done;
  logic       mapped;
  logic [7:0] status_byte;
  assign acc_done = PSEL && PENABLE && PREADY;
  assign wr_done  = acc_done && PWRITE;
  assign rd_done  = acc_done && !PWRITE;
  assign mapped   = (PADDR == `OFS_CONTROL_ONE) || (PADDR == `OFS_CONTROL_TWO)
                 || (PADDR == `OFS_STATUS) || (PADDR == `OFS_DATA);
  assign status_byte = {parity_error_flag, framing_error_flag, overrun_flag,
                        rx_buffer_full_flag, transmit_end_flag,
                        tx_buffer_empty_flag, 2'b00};

  // One wait state: ready answers the second access cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        case (PADDR)
          `OFS_CONTROL_ONE: PRDATA <= {24'h00_0000, serial_control_one};
          `OFS_CONTROL_TWO: PRDATA <= {31'h0000_0000, receive_stop_length};
          `OFS_STATUS:      PRDATA <= {24'h00_0000, status_byte};
          `OFS_DATA:        PRDATA <= {24'h00_0000, receive_buffer};
          default:          PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      serial_control_one  <= `RST_CONTROL_ONE;
      receive_stop_length <= `RST_CONTROL_TWO;
    end else if (wr_done) begin
      if (PADDR == `OFS_CONTROL_ONE) begin
        serial_control_one <= PWDATA[7:0];
      end
      if (PADDR == `OFS_CONTROL_TWO) begin
        receive_stop_length <= PWDATA[`BIT_RX_STOP_LEN];
      end
    end
  end

  // Status read arms one buffer access in each direction
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tx_armed     <= 1'b0;
      rx_armed     <= 1'b0;
      overrun_seen <= 1'b0;
    end else if (rd_done && PADDR == `OFS_STATUS) begin
      tx_armed     <= 1'b1;
      rx_armed     <= 1'b1;
      overrun_seen <= overrun_flag;
    end else if (acc_done && PADDR == `OFS_DATA) begin
      if (PWRITE) begin
        tx_armed <= 1'b0;
      end else begin
        rx_armed <= 1'b0;
      end
    end
  end

  // ********************
  // Baud timing
  // ********************
  function automatic logic [8:0] divisor_of(input logic [2:0] code);
    case (code)
      3'h0:    divisor_of = `DIV_CODE0;
      3'h1:    divisor_of = `DIV_CODE1;
      3'h2:    divisor_of = `DIV_CODE2;
      3'h3:    divisor_of = `DIV_CODE3;
      3'h4:    divisor_of = `DIV_CODE4;
      3'h5:    divisor_of = `DIV_CODE5;
      default: divisor_of = `DIV_CODE7;
    endcase
  endfunction : divisor_of

  logic [8:0] div_cnt;
  logic       rt_tick;
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      div_cnt <= 9'h000;
      rt_tick <= 1'b0;
    end else if (baud_select_field == `BAUD_TIMER_CODE) begin
      div_cnt <= 9'h000;
      rt_tick <= TIMER_THREE_OUTPUT;
    end else begin
      // One tick per transfer clock, sixteen per bit
      if (div_cnt >= divisor_of(baud_select_field) - 9'h001) begin
        div_cnt <= 9'h000;
        rt_tick <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 9'h001;
        rt_tick <= 1'b0;
      end
    end
  end

  // ********************
  // Transmitter
  // ********************
  logic tx_start;
  logic tx_busy;
  logic tx_done;
  logic tx_accept;
  // Waits for a fresh buffer; a stale one never restarts
  assign tx_start  = transmit_enable_bit && !tx_buffer_empty_flag && !tx_busy;
  assign tx_accept = wr_done && PADDR == `OFS_DATA && tx_armed
                  && tx_buffer_empty_flag;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      transmit_buffer <= 8'h00;
    end else if (tx_accept) begin
      transmit_buffer <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tx_buffer_empty_flag <= `RST_TX_EMPTY;
      transmit_end_flag    <= `RST_TX_END;
      TRANSMIT_INTERRUPT   <= 1'b0;
    end else begin
      TRANSMIT_INTERRUPT <= tx_start;
      if (tx_start) begin
        tx_buffer_empty_flag <= 1'b1;
        transmit_end_flag    <= 1'b0;
      end else if (tx_accept) begin
        tx_buffer_empty_flag <= 1'b0;
      end else if (tx_done && tx_buffer_empty_flag) begin
        transmit_end_flag <= 1'b1;
      end
    end
  end

  serial_tx u_tx (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .rt_tick  (rt_tick),
    .start    (tx_start),
    .data     (transmit_buffer),
    .par_en   (parity_enable_bit),
    .even     (even_parity_bit),
    .two_stop (transmit_stop_length),
    .txd      (TXD),
    .busy     (tx_busy),
    .done     (tx_done)
  );

  // ********************
  // Receiver
  // ********************
  rx_state_t  rx_state;
  logic [3:0] rtc;
  logic [2:0] samples;
  logic [2:0] bit_idx;
  logic [7:0] rx_shift;
  logic       par_bad;
  logic       stop_bad;
  logic       rx_load;
  logic       rx_ovr;
  logic       rx_parity_error_flag;
  logic       rx_framing_error_flag;
  logic       bit_val;
  logic       bit_end;
  assign bit_val = (samples[0] & samples[1]) | (samples[1] & samples[2])
                 | (samples[0] & samples[2]);
  assign bit_end = rt_tick && rtc == `RT_LAST;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rx_state <= RX_IDLE;
      rtc      <= 4'h0;
      samples  <= 3'h0;
      bit_idx  <= 3'h0;
      rx_shift <= 8'h00;
      par_bad  <= 1'b0;
      stop_bad <= 1'b0;
      rx_load  <= 1'b0;
      rx_ovr   <= 1'b0;
      rx_parity_error_flag  <= 1'b0;
      rx_framing_error_flag  <= 1'b0;
    end else begin
      rx_load <= 1'b0;
      rx_ovr  <= 1'b0;
      rx_parity_error_flag <= 1'b0;
      rx_framing_error_flag <= 1'b0;
      if (rt_tick && rx_state != RX_IDLE) begin
        rtc <= rtc + 4'h1;
        if (rtc == `RT_SAMPLE_A || rtc == `RT_SAMPLE_B || rtc == `RT_SAMPLE_C) begin
          samples <= {RXD, samples[2:1]};
        end
      end
      case (rx_state)
        RX_IDLE: begin
          // Enable is looked at only between frames
          if (rt_tick && receive_enable_bit && !overrun_flag && !RXD) begin
            rx_state <= RX_START;
            rtc      <= 4'h1;
            par_bad  <= 1'b0;
            stop_bad <= 1'b0;
          end
        end
        RX_START: begin
          if (bit_end) begin
            rx_state <= bit_val ? RX_IDLE : RX_DATA; // False start drops back
            bit_idx  <= 3'h0;
          end
        end
        RX_DATA: begin
          if (bit_end) begin
            rx_shift <= {bit_val, rx_shift[7:1]};
            bit_idx  <= bit_idx + 3'h1;
            if (bit_idx == 3'h7) begin
              rx_state <= parity_enable_bit ? RX_PAR : RX_STOP1;
            end
          end
        end
        RX_PAR: begin
          if (bit_end) begin
            par_bad  <= bit_val != parity_of(rx_shift, even_parity_bit);
            rx_state <= RX_STOP1;
          end
        end
        RX_STOP1, RX_STOP2: begin
          if (bit_end) begin
            if (rx_state == RX_STOP1 && receive_stop_length) begin
              stop_bad <= !bit_val;
              rx_state <= RX_STOP2;
            end else begin
              rx_state <= RX_IDLE;
              // Full buffer: character dropped, only overrun raised
              rx_ovr  <= rx_buffer_full_flag;
              rx_load <= !rx_buffer_full_flag;
              rx_parity_error_flag <= !rx_buffer_full_flag && par_bad;
              rx_framing_error_flag <= !rx_buffer_full_flag && (stop_bad || !bit_val);
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ********************
  // Receive flags
  // ********************
  logic rx_clear;
  assign rx_clear = rd_done && PADDR == `OFS_DATA && rx_armed;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      receive_buffer      <= `RST_RX_BUFFER;
      rx_buffer_full_flag <= 1'b0;
      parity_error_flag   <= 1'b0;
      framing_error_flag  <= 1'b0;
      overrun_flag        <= 1'b0;
      RECEIVE_INTERRUPT   <= 1'b0;
    end else begin
      RECEIVE_INTERRUPT <= rx_load;
      if (rx_load) begin
        receive_buffer <= rx_shift;
      end
      // Set wins over a clear in the same cycle
      if (rx_load) begin
        rx_buffer_full_flag <= 1'b1;
      end else if (rx_clear) begin
        rx_buffer_full_flag <= 1'b0;
      end
      if (rx_parity_error_flag) begin
        parity_error_flag <= 1'b1;
      end else if (rx_clear) begin
        parity_error_flag <= 1'b0;
      end
      if (rx_framing_error_flag) begin
        framing_error_flag <= 1'b1;
      end else if (rx_clear) begin
        framing_error_flag <= 1'b0;
      end
      if (rx_ovr) begin
        overrun_flag <= 1'b1;
      end else if (rx_clear && overrun_seen) begin
        overrun_flag <= 1'b0;
      end
    end
  end

endmodule : serial_port

// [serial_port_monitor.sv]
// Port checker of the serial port, bound to its top module
`timescale 1ns/1ps
`include "serial_params.svh"
module serial_port_monitor (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST_N,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Line and events
  input wire logic        TXD,
  input wire logic        TRANSMIT_INTERRUPT,
  input wire logic        RECEIVE_INTERRUPT
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  // ********************
  // Bus answer
  // ********************
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence one_wait_s;
    !PREADY ##1 PREADY;
  endsequence
  a_ready_one_wait: assert property (setup_s |=> one_wait_s)
    else $error("pready not after exactly one wait");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (PREADY |-> PSLVERR == !(PADDR inside
    {`OFS_CONTROL_ONE, `OFS_CONTROL_TWO, `OFS_STATUS, `OFS_DATA}))
    else $error("pslverr does not match address");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  // ********************
  // Serial events
  // ********************
  // Frames last at least 160 ticks, so eight quiet cycles always hold
  a_txint_gap: assert property (TRANSMIT_INTERRUPT |=> !TRANSMIT_INTERRUPT [*8])
    else $error("transmit pulse too long");
  // Line is registered after the engine goes busy, so it drops one cycle after the pulse
  a_start_low: assert property (TRANSMIT_INTERRUPT |=> !TXD [*8])
    else $error("no low start bit at frame start");
  a_rxint_gap: assert property (RECEIVE_INTERRUPT |=> !RECEIVE_INTERRUPT [*8])
    else $error("receive pulse too long");
  a_idle_reset: assert property ($rose(RST_N) |-> TXD)
    else $error("line not high after reset");
endmodule : serial_port_monitor

bind serial_port serial_port_monitor mon (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TXD(TXD), .TRANSMIT_INTERRUPT(TRANSMIT_INTERRUPT),
  .RECEIVE_INTERRUPT(RECEIVE_INTERRUPT));

// [serial_remote.sv]
// Remote serial device: frame sender on the receive line, frame catcher on the transmit line
`timescale 1ns/1ps
module serial_remote (
  // Clock and lines
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  int         bit_cyc = 208;
  logic       par_en = 1'b0;
  logic [7:0] got;
  logic       got_par;
  logic       got_stop;
  int         got_count = 0;
  int         now = 0;
  int         last_start = 0;
  int         gap = 0;
  initial rxd = 1'b1;
  always @(posedge clk) now <= now + 1;
  // Idle mark level between frames
  task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (bit_cyc) @(posedge clk);
    end
    if (par_en) begin
      rxd <= (^b) ^ bad_par;
      repeat (bit_cyc) @(posedge clk);
    end
    rxd <= ~bad_stop;
    repeat (bit_cyc) @(posedge clk);
    rxd <= 1'b1;
  endtask : send
  // Samples at bit centres; gap spans two start edges
  always begin
    @(posedge clk iff txd === 1'b0);
    gap = now - last_start;
    last_start = now;
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      got[i] = txd;
    end
    if (par_en) begin
      repeat (bit_cyc) @(posedge clk);
      got_par = txd;
    end
    repeat (bit_cyc) @(posedge clk);
    got_stop = txd;
    got_count++;
  end
endmodule : serial_remote

// [serial_tx.sv]
// Transmit shift engine: builds and shifts one frame per start pulse
`timescale 1ns/1ps
`include "serial_params.svh"

module serial_tx
  import serial_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Timing
  input  wire logic       rt_tick,
  // Frame request
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic       par_en,
  input  wire logic       even,
  input  wire logic       two_stop,
  // Line and status
  output logic            txd,
  output logic            busy,
  output logic            done
);

  logic [11:0] shifter;
  logic [3:0]  bits_left;
  logic [3:0]  rtc;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shifter   <= 12'hFFF;
      bits_left <= 4'h0;
      rtc       <= 4'h0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        // Start low, LSB first, optional parity, stop bits high
        shifter   <= par_en ? {2'b11, parity_of(data, even), data, 1'b0}
                            : {3'b111, data, 1'b0};
        bits_left <= `FRAME_BASE_LEN + {3'h0, par_en} + {3'h0, two_stop};
        rtc       <= 4'h0;
        busy      <= 1'b1;
      end else if (busy && rt_tick) begin
        rtc <= rtc + 4'h1;
        if (rtc == `RT_LAST) begin
          shifter <= {1'b1, shifter[11:1]};
          if (bits_left == 4'h1) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
          bits_left <= bits_left - 4'h1;
        end
      end
    end
  end

  // Idle line stays high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txd <= 1'b1;
    end else begin
      txd <= busy ? shifter[0] : 1'b1;
    end
  end

endmodule : serial_tx

// [tb_serial_port.sv]
// Self-checking bench of the serial port: APB host, remote device, timer source
`timescale 1ns/1ps
`include "serial_params.svh"
module tb_serial_port;
  logic        MCLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic        TIMER_THREE_OUTPUT = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, RXD, TXD, TRANSMIT_INTERRUPT, RECEIVE_INTERRUPT;
  logic [1:0]  tcnt = 2'h0;
  logic        seen;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #2.5 MCLK = ~MCLK;
  // Timer pulse every fourth cycle: 64-cycle bits on code 110
  always @(posedge MCLK) begin
    tcnt <= tcnt + 2'h1;
    TIMER_THREE_OUTPUT <= (tcnt == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  serial_port DUT (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TIMER_THREE_OUTPUT(TIMER_THREE_OUTPUT), .RXD(RXD), .TXD(TXD),
    .TRANSMIT_INTERRUPT(TRANSMIT_INTERRUPT), .RECEIVE_INTERRUPT(RECEIVE_INTERRUPT));
  serial_remote remote (.clk(MCLK), .txd(TXD), .rxd(RXD));
  // ********************
  // Shared tasks
  // ********************
  task automatic tally_and_finish();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    chk("pready", 32'h1, {31'h0, PREADY});
    // Idle cycle keeps the next setup from reassigning select in this time step
    @(posedge MCLK);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, {24'h0, x}, r);
  endtask : rd
  task automatic wait_tx(input int n);
    int k;
    k = 0;
    while (remote.got_count < n && k < 5000) begin
      @(posedge MCLK);
      k++;
    end
    chk("frames", n, remote.got_count);
  endtask : wait_tx
  task automatic rx_frame(input logic [7:0] b, input logic bp, input logic bs);
    seen = 1'b0;
    fork
      remote.send(b, bp, bs);
      repeat (3000) begin
        @(posedge MCLK);
        if (RECEIVE_INTERRUPT === 1'b1) seen = 1'b1;
      end
    join
  endtask : rx_frame
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(`OFS_STATUS, 8'h0C, "status");
    rd(`OFS_DATA, 8'h00, "rx buffer");
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped data", 32'h0, r);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("txd", 32'h1, {31'h0, TXD});
  endtask : t_reset
  task automatic t_tx_odd();
    remote.par_en = 1'b1;
    wr(`OFS_CONTROL_ONE, 8'h11);
    repeat (50) @(posedge MCLK);
    chk("txd", 32'h1, {31'h0, TXD});
    rd(`OFS_STATUS, 8'h0C, "status");
    wr(`OFS_DATA, 8'hA5);
    wr(`OFS_DATA, 8'h5A);
    wait_tx(1);
    chk("tx byte", 32'hA5, {24'h0, remote.got});
    chk("parity", {31'h0, ~^8'hA5}, {31'h0, remote.got_par});
    chk("stop", 32'h1, {31'h0, remote.got_stop});
    repeat (2600) @(posedge MCLK);
    chk("frames", 32'h1, remote.got_count);
    rd(`OFS_STATUS, 8'h0C, "status");
  endtask : t_tx_odd
  task automatic t_tx_timer();
    wr(`OFS_CONTROL_ONE, 8'h00);
    remote.bit_cyc = 64;
    remote.par_en = 1'b0;
    wr(`OFS_CONTROL_ONE, 8'hC5);
    rd(`OFS_STATUS, 8'h0C, "status");
    wr(`OFS_DATA, 8'h81);
    rd(`OFS_STATUS, 8'h04, "status in frame");
    wr(`OFS_DATA, 8'h7E);
    wait_tx(3);
    chk("tx byte", 32'h7E, {24'h0, remote.got});
    // 176 ticks of 4 cycles; first tick may come up to one period after the start
    chk("two stop gap", 32'h1, {31'h0, remote.gap > 700 && remote.gap < 768});
  endtask : t_tx_timer
  task automatic t_rx();
    wr(`OFS_CONTROL_ONE, 8'hC0);
    remote.bit_cyc = 208;
    remote.par_en = 1'b1;
    wr(`OFS_CONTROL_ONE, 8'h1A);
    rx_frame(8'h3C, 1'b0, 1'b0);
    chk("rx pulse", 32'h1, {31'h0, seen});
    rd(`OFS_STATUS, 8'h1C, "status");
    rd(`OFS_DATA, 8'h3C, "rx buffer");
    rd(`OFS_STATUS, 8'h0C, "status");
    for (int k = 0; k < 2; k++) begin
      rx_frame(8'h96, k == 0, k == 1);
      rd(`OFS_STATUS, k == 0 ? 8'h9C : 8'h5C, "error status");
      rd(`OFS_DATA, 8'h96, "rx buffer");
      rd(`OFS_STATUS, 8'h0C, "status");
    end
    rd(`OFS_CONTROL_ONE, 8'h1A, "control one");
    wr(`OFS_CONTROL_TWO, 8'h01);
    rd(`OFS_CONTROL_TWO, 8'h01, "control two");
    rx_frame(8'h69, 1'b0, 1'b1);
    rd(`OFS_STATUS, 8'h5C, "two stop status");
    rd(`OFS_DATA, 8'h69, "rx buffer");
    rd(`OFS_STATUS, 8'h0C, "status");
    wr(`OFS_CONTROL_TWO, 8'h00);
  endtask : t_rx
  task automatic t_overrun();
    rx_frame(8'h11, 1'b0, 1'b0);
    rx_frame(8'h22, 1'b0, 1'b0);
    rd(`OFS_STATUS, 8'h3C, "status");
    rx_frame(8'h33, 1'b0, 1'b0);
    chk("rx pulse", 32'h0, {31'h0, seen});
    rd(`OFS_DATA, 8'h11, "rx buffer");
    rd(`OFS_STATUS, 8'h0C, "status");
    rx_frame(8'h44, 1'b0, 1'b0);
    rd(`OFS_STATUS, 8'h1C, "status");
    rx_frame(8'h55, 1'b0, 1'b0);
    rd(`OFS_DATA, 8'h44, "rx buffer");
    rd(`OFS_STATUS, 8'h2C, "late overrun");
    rd(`OFS_DATA, 8'h44, "rx buffer");
    rd(`OFS_STATUS, 8'h0C, "status");
  endtask : t_overrun
  task automatic t_rx_disable();
    fork
      rx_frame(8'hA5, 1'b0, 1'b0);
      begin
        repeat (1000) @(posedge MCLK);
        // Parity settings kept: only the receive enable is dropped mid-frame
        wr(`OFS_CONTROL_ONE, 8'h18);
      end
    join
    chk("rx pulse", 32'h1, {31'h0, seen});
    rd(`OFS_STATUS, 8'h1C, "status");
    rd(`OFS_DATA, 8'hA5, "rx buffer");
    rx_frame(8'h5A, 1'b0, 1'b0);
    chk("rx pulse", 32'h0, {31'h0, seen});
  endtask : t_rx_disable
  initial begin
    repeat (12) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    t_reset();
    t_tx_odd();
    t_tx_timer();
    t_rx();
    t_overrun();
    t_rx_disable();
    tally_and_finish();
  end
endmodule : tb_serial_port
